// ===== core/pulse_detect_top.sv
// Purpose: Pulse and freefall detection with its register port.
// Assumes: Samples, register strobes and clear come from core-clock logic.
// Notes: Settings are best changed while no event is in progress.
//
// Overview of operation
// - Control register one holds Z disable at 0x20 and Y at 0x10.
// - A disable bit at one removes its axis; zero includes it.
// - Eight-bit threshold compared with enabled axes; 0x40 means 4 g.
// - First pulse width register counts half milliseconds, up to 127.5 ms.
// - Latency register counts milliseconds: pulse gap or freefall time.
// - Second window register counts milliseconds up to 255 ms.
// - Polarity bit zero selects OR logic; host clears it by masked write.
// - Polarity one: all enabled axes below threshold past latency flags.
// - OR logic: crossing threshold and returning within width is a pulse.
// - Double pulse: first pulse, latency, then second pulse inside window.

`default_nettype none

module pulse_detect_top
    import pulse_det_pkg::*;
#(
    parameter int HALF_MS_CYCLES = HALF_MS_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic sample_valid_i,
    input wire logic [7:0] accel_x_i,
    input wire logic [7:0] accel_y_i,
    input wire logic [7:0] accel_z_i,
    input wire logic pulse_clear_i,
    output logic pulse_int_o,
    output logic [2:0] pulse_source_o,
    output logic double_pulse_o
);

    localparam int PRE_W = $clog2(HALF_MS_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(HALF_MS_CYCLES - 1);

    // ******************************************************
    // Registers
    // ******************************************************
    logic [7:0] ctrl_one_ff;
    logic [7:0] ctrl_two_ff;
    logic [7:0] threshold_ff;
    logic [7:0] width_ff;
    logic [7:0] latency_ff;
    logic [7:0] window_ff;
    logic reg_we;

    assign reg_we = ce_i && reg_wr_i;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_one_ff <= RST_CTRL_ONE;
        end else if (reg_we && reg_addr_i == ADDR_CTRL_ONE) begin
            ctrl_one_ff <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_two_ff <= RST_CTRL_TWO;
        end else if (reg_we && reg_addr_i == ADDR_CTRL_TWO) begin
            ctrl_two_ff <= reg_wdata_i & CTRL_TWO_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            threshold_ff <= RST_THRESHOLD;
        end else if (reg_we && reg_addr_i == ADDR_THRESHOLD) begin
            threshold_ff <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            width_ff <= RST_WIDTH;
        end else if (reg_we && reg_addr_i == ADDR_WIDTH) begin
            width_ff <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            latency_ff <= RST_LATENCY;
        end else if (reg_we && reg_addr_i == ADDR_LATENCY) begin
            latency_ff <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            window_ff <= RST_WINDOW;
        end else if (reg_we && reg_addr_i == ADDR_WINDOW) begin
            window_ff <= reg_wdata_i;
        end
    end

    // Read data is registered; unmapped offsets read as zero.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i && reg_rd_i) begin
            if (reg_addr_i == ADDR_CTRL_ONE) begin
                reg_rdata_o <= ctrl_one_ff;
            end else if (reg_addr_i == ADDR_CTRL_TWO) begin
                reg_rdata_o <= ctrl_two_ff;
            end else if (reg_addr_i == ADDR_THRESHOLD) begin
                reg_rdata_o <= threshold_ff;
            end else if (reg_addr_i == ADDR_WIDTH) begin
                reg_rdata_o <= width_ff;
            end else if (reg_addr_i == ADDR_LATENCY) begin
                reg_rdata_o <= latency_ff;
            end else if (reg_addr_i == ADDR_WINDOW) begin
                reg_rdata_o <= window_ff;
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end
    end

    // ******************************************************
    // Time base
    // ******************************************************
    logic [PRE_W-1:0] pre_cnt_ff;
    logic ms_phase_ff;
    logic tick_half_ms;
    logic tick_ms;

    assign tick_half_ms = ce_i && (pre_cnt_ff == PRE_LAST);
    assign tick_ms = tick_half_ms && ms_phase_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pre_cnt_ff <= '0;
        end else if (ce_i) begin
            pre_cnt_ff <= tick_half_ms ? '0 : pre_cnt_ff + PRE_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ms_phase_ff <= 1'b0;
        end else if (tick_half_ms) begin
            ms_phase_ff <= !ms_phase_ff;
        end
    end

    // ******************************************************
    // Axis qualification
    // ******************************************************
    pulse_cfg_if cfg ();
    logic [7:0] mag [NUM_AXES];
    logic [NUM_AXES-1:0] axis_pulse;
    logic [NUM_AXES-1:0] axis_en;
    logic [NUM_AXES-1:0] axis_below;
    logic [NUM_AXES-1:0] hit;
    logic and_mode;

    assign cfg.ce = ce_i;
    assign cfg.tick_half_ms = tick_half_ms;
    assign cfg.sample_valid = sample_valid_i;
    assign cfg.threshold = threshold_ff;
    assign cfg.width = width_ff;

    assign mag[0] = magnitude(accel_x_i);
    assign mag[1] = magnitude(accel_y_i);
    assign mag[2] = magnitude(accel_z_i);

    assign axis_en = ~{ctrl_one_ff[Z_DISABLE_BIT],
                       ctrl_one_ff[Y_DISABLE_BIT],
                       ctrl_one_ff[X_DISABLE_BIT]};
    assign and_mode = ctrl_two_ff[POLARITY_BIT];
    assign hit = axis_pulse & axis_en & {NUM_AXES{!and_mode}};

    for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
        assign axis_below[a] = (mag[a] < threshold_ff);

        pulse_qualifier u_qual (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .cfg(cfg),
            .magnitude_i(mag[a]),
            .pulse_o(axis_pulse[a])
        );
    end

    // ******************************************************
    // Double pulse sequencer
    // ******************************************************
    seq_state_t state_ff;
    logic [7:0] seq_cnt_ff;
    logic [NUM_AXES-1:0] seq_set;
    logic seq_double;

    // A zero second window selects plain single-pulse reporting.
    // pulse latency window
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_ff <= SEQ_IDLE;
            seq_cnt_ff <= 8'h00;
        end else if (ce_i) begin
            if (and_mode) begin
                state_ff <= SEQ_IDLE;
                seq_cnt_ff <= 8'h00;
            end else begin
                case (state_ff)
                    SEQ_IDLE: begin
                        seq_cnt_ff <= 8'h00;
                        if (|hit && window_ff != 8'h00) begin
                            state_ff <= SEQ_LATENCY;
                        end
                    end
                    SEQ_LATENCY: begin
                        if (seq_cnt_ff >= latency_ff) begin
                            state_ff <= SEQ_WINDOW;
                            seq_cnt_ff <= 8'h00;
                        end else if (tick_ms) begin
                            seq_cnt_ff <= seq_cnt_ff + 8'h01;
                        end
                    end
                    SEQ_WINDOW: begin
                        if (|hit || seq_cnt_ff >= window_ff) begin
                            state_ff <= SEQ_IDLE;
                            seq_cnt_ff <= 8'h00;
                        end else if (tick_ms) begin
                            seq_cnt_ff <= seq_cnt_ff + 8'h01;
                        end
                    end
                    default: begin
                        state_ff <= SEQ_IDLE;
                    end
                endcase
            end
        end
    end

    // ******************************************************
    // Freefall timer
    // ******************************************************
    logic [8:0] fall_cnt_ff;
    logic fall_done_ff;
    logic all_below;
    logic fall_fire;

    assign all_below = and_mode && (|axis_en) &&
                       (&(axis_below | ~axis_en));
    assign fall_fire = all_below && !fall_done_ff &&
                       (fall_cnt_ff > {1'b0, latency_ff});

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fall_cnt_ff <= 9'h000;
            fall_done_ff <= 1'b0;
        end else if (ce_i) begin
            if (!all_below) begin
                fall_cnt_ff <= 9'h000;
                fall_done_ff <= 1'b0;
            end else begin
                if (tick_ms && fall_cnt_ff != 9'h1ff) begin
                    fall_cnt_ff <= fall_cnt_ff + 9'h001;
                end
                if (fall_fire) begin
                    fall_done_ff <= 1'b1;
                end
            end
        end
    end

    // ******************************************************
    // Event flags
    // ******************************************************
    always_comb begin
        seq_set = '0;
        seq_double = 1'b0;
        if (!and_mode) begin
            if (state_ff == SEQ_IDLE && window_ff == 8'h00) begin
                seq_set = hit;
            end else if (state_ff == SEQ_WINDOW && |hit) begin
                seq_set = hit;
                seq_double = 1'b1;
            end
        end
        if (fall_fire) begin
            seq_set = axis_en;
        end
    end

    // A new event in the clear cycle survives the clear.
    // sticky source flags
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pulse_source_o <= 3'h0;
            double_pulse_o <= 1'b0;
        end else if (ce_i) begin
            pulse_source_o <= (pulse_source_o & {3{!pulse_clear_i}}) |
                              seq_set;
            double_pulse_o <= (double_pulse_o && !pulse_clear_i) ||
                              seq_double;
        end
    end

    assign pulse_int_o = |pulse_source_o;

endmodule

`default_nettype wire

// ===== core/pulse_det_pkg.sv
// Purpose: Shared constants and types of the pulse-detection block.
// Assumes: Byte-wide register port, 100 MHz core clock.
// Notes: Every offset, field position, reset value and time lives here.

`default_nettype none

package pulse_det_pkg;

    // ******************************************************
    // Register offsets
    // ******************************************************
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h18;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h19;
    localparam logic [7:0] ADDR_THRESHOLD = 8'h1b;
    localparam logic [7:0] ADDR_WIDTH = 8'h1c;
    localparam logic [7:0] ADDR_LATENCY = 8'h1d;
    localparam logic [7:0] ADDR_WINDOW = 8'h1e;

    // ******************************************************
    // Field positions and masks
    // ******************************************************
    localparam int Z_DISABLE_BIT = 5;
    localparam int Y_DISABLE_BIT = 4;
    localparam int X_DISABLE_BIT = 3;
    localparam int POLARITY_BIT = 1;
    localparam logic [7:0] CTRL_TWO_MASK = 8'h07;

    // ******************************************************
    // Reset values
    // ******************************************************
    localparam logic [7:0] RST_CTRL_ONE = 8'h00;
    localparam logic [7:0] RST_CTRL_TWO = 8'h00;
    localparam logic [7:0] RST_THRESHOLD = 8'h00;
    localparam logic [7:0] RST_WIDTH = 8'h00;
    localparam logic [7:0] RST_LATENCY = 8'h00;
    localparam logic [7:0] RST_WINDOW = 8'h00;

    // ******************************************************
    // Timing
    // ******************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int HALF_MS_NS = 500000;
    localparam int HALF_MS_CYCLES_DEF =
        (HALF_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int NUM_AXES = 3;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_LATENCY,
        SEQ_WINDOW
    } seq_state_t;

    // Magnitude of a two's complement sample, saturated at 127.
    function automatic logic [7:0] magnitude(input logic [7:0] s);
        logic [7:0] m;
        m = s[7] ? 8'((~s) + 8'h01) : s;
        if (m[7]) begin
            m = 8'h7f;
        end
        return m;
    endfunction

endpackage

`default_nettype wire

// ===== core/pulse_cfg_if.sv
// Purpose: Carries shared timing and settings to the axis qualifiers.
// Assumes: All members belong to the core clock domain.
// Notes: The top drives every member by direct assigns; the src modport is not used.

`default_nettype none

interface pulse_cfg_if;
    logic ce;
    logic tick_half_ms;
    logic sample_valid;
    logic [7:0] threshold;
    logic [7:0] width;

    modport src (
        output ce,
        output tick_half_ms,
        output sample_valid,
        output threshold,
        output width
    );

    modport dst (
        input ce,
        input tick_half_ms,
        input sample_valid,
        input threshold,
        input width
    );
endinterface

`default_nettype wire

// ===== core/pulse_qualifier.sv
// Purpose: Qualifies one axis excursion at or above threshold as a pulse.
// Assumes: Magnitude arrives with the shared sample strobe.
// Notes: Pulse output is a one-cycle registered strobe.

`default_nettype none

module pulse_qualifier
    import pulse_det_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    pulse_cfg_if.dst cfg,
    input wire logic [7:0] magnitude_i,
    output logic pulse_o
);

    logic above_ff;
    logic [7:0] width_cnt_ff;
    logic above;

    assign above = (magnitude_i >= cfg.threshold);

    // ******************************************************
    // Excursion tracking
    // ******************************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            above_ff <= 1'b0;
        end else if (cfg.ce && cfg.sample_valid) begin
            above_ff <= above;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            width_cnt_ff <= 8'h00;
        end else if (cfg.ce) begin
            if (cfg.sample_valid && above && !above_ff) begin
                width_cnt_ff <= 8'h00;
            end else if (above_ff && cfg.tick_half_ms &&
                         width_cnt_ff != 8'hff) begin
                width_cnt_ff <= width_cnt_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pulse_o <= 1'b0;
        end else if (cfg.ce) begin
            pulse_o <= cfg.sample_valid && above_ff && !above &&
                       (width_cnt_ff < cfg.width);
        end
    end

endmodule

`default_nettype wire

// ===== core/pulse_detect_top_end.sv
// Purpose: Holds no logic of the pulse detector.
// Assumes: Nothing is defined here.
// Notes: The detector is complete without this unit.

// ===== bench/pulse_detect_top_properties.sv
// Purpose: Port-level properties of the pulse detector.
// Assumes: One clock, synchronous active-low reset.
// Notes: Attached to the top module by the bind at the foot.

`default_nettype none

module pulse_detect_checker
    import pulse_det_pkg::*;
#(
    parameter int HALF_MS_CYCLES = HALF_MS_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic sample_valid_i,
    input wire logic [7:0] accel_x_i,
    input wire logic [7:0] accel_y_i,
    input wire logic [7:0] accel_z_i,
    input wire logic pulse_clear_i,
    input wire logic pulse_int_o,
    input wire logic [2:0] pulse_source_o,
    input wire logic double_pulse_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********************
    // Properties
    // ********************
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic mapped;
    assign mapped = reg_addr_i inside {ADDR_CTRL_ONE, ADDR_CTRL_TWO,
        ADDR_THRESHOLD, ADDR_WIDTH, ADDR_LATENCY, ADDR_WINDOW};

    a_reset_clears: assert property (disable iff (1'b0) !rst_n_i |=>
        pulse_source_o == 3'h0 && !double_pulse_o && reg_rdata_o == 8'h00)
        else $error("reset left flags or read data set");
    a_int_follows: assert property (pulse_int_o == (|pulse_source_o))
        else $error("interrupt does not match source flags");
    a_flags_sticky: assert property (!pulse_clear_i |=>
        (pulse_source_o & $past(pulse_source_o)) == $past(pulse_source_o))
        else $error("source flag dropped without clear");
    a_freeze_ce: assert property (!ce_i |=> $stable(pulse_source_o) &&
        $stable(double_pulse_o) && $stable(reg_rdata_o))
        else $error("state moved while clock enable low");
    a_rdata_holds: assert property (!(ce_i && reg_rd_i) |=>
        $stable(reg_rdata_o))
        else $error("read data changed without a read");
    a_write_readback: assert property (
        ce_i && reg_wr_i && !reg_rd_i && mapped
        ##1 ce_i && !reg_wr_i && !reg_rd_i
        ##1 ce_i && reg_rd_i && !reg_wr_i && reg_addr_i == $past(reg_addr_i, 2)
        |=> reg_rdata_o == ($past(reg_wdata_i, 3) &
            ($past(reg_addr_i, 3) == ADDR_CTRL_TWO ? CTRL_TWO_MASK : 8'hff)))
        else $error("register read back differs from write");
    a_unmapped_zero: assert property (ce_i && reg_rd_i && !mapped |=>
        reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_two_upper: assert property (
        ce_i && reg_rd_i && reg_addr_i == ADDR_CTRL_TWO |=>
        reg_rdata_o[7:3] == 5'h00)
        else $error("control two upper bits not zero");
    a_double_has_src: assert property (double_pulse_o |->
        pulse_source_o != 3'h0)
        else $error("double flag without source flag");
endmodule

bind pulse_detect_top pulse_detect_checker #(
    .HALF_MS_CYCLES(HALF_MS_CYCLES)
) chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .sample_valid_i(sample_valid_i), .accel_x_i(accel_x_i),
    .accel_y_i(accel_y_i), .accel_z_i(accel_z_i),
    .pulse_clear_i(pulse_clear_i), .pulse_int_o(pulse_int_o),
    .pulse_source_o(pulse_source_o), .double_pulse_o(double_pulse_o)
);

`default_nettype wire

// ===== bench/host_port_model.sv
// Purpose: Host side of the register port.
// Assumes: Strobes are taken on the edge after they are driven.
// Notes: Released address and data show inverted values, not the old ones.

`default_nettype none

module host_port_model (
    input wire logic clk_i,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] old_v;

    initial begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    task write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask

    task read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        @(posedge clk_i);
        d = reg_rdata_i;
    endtask

    task rmw(input logic [7:0] a, input logic [7:0] keep,
             input logic [7:0] set);
        read_reg(a, old_v);
        write_reg(a, (old_v & keep) | set);
    endtask
endmodule

`default_nettype wire

// ===== bench/accel_pulse_detection_config_bench.sv
// Purpose: Self-checking bench for the pulse detector.
// Assumes: Four clock cycles per half millisecond.
// Notes: Register traffic goes through the host model.

`default_nettype none

module accel_pulse_detection_config_bench
    import pulse_det_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic sv = 1'b0;
    logic clr = 1'b0;
    logic [7:0] acc [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0] addr, wdata, rdata, rd_v;
    logic wr, rd, int_o, dbl;
    logic [2:0] src;
    int num_errors = 0;
    int n_checks = 0;
    logic [7:0] row_a [8] = '{8'h18, 8'h19, 8'h1b, 8'h1c, 8'h1d, 8'h1e,
        8'h1a, 8'h1f};
    logic [7:0] row_d [8] = '{8'hff, 8'hff, 8'h40, 8'hff, 8'h5a, 8'h82,
        8'h55, 8'haa};
    logic [7:0] row_e [8] = '{8'hff, 8'h07, 8'h40, 8'hff, 8'h5a, 8'h82,
        8'h00, 8'h00};

    always #5 clk_i = ~clk_i;

    host_port_model host (
        .clk_i(clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata)
    );

    pulse_detect_top #(
        .HALF_MS_CYCLES(4)
    ) uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .sample_valid_i(sv), .accel_x_i(acc[0]),
        .accel_y_i(acc[1]), .accel_z_i(acc[2]), .pulse_clear_i(clr),
        .pulse_int_o(int_o), .pulse_source_o(src), .double_pulse_o(dbl)
    );

    // ********************
    // Helpers
    // ********************
    task report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task check(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task hit(input int ax, input logic [7:0] v);
        @(posedge clk_i);
        acc[ax] <= v;
        sv <= 1'b1;
        @(posedge clk_i);
        sv <= 1'b0;
    endtask

    // A short excursion: one sample above, the next back at rest.
    task pulse(input int ax, input logic [7:0] v);
        hit(ax, v);
        hit(ax, 8'h00);
    endtask

    task clear_flags();
        @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
    endtask

    task wait_int(input int bound);
        int k;
        k = 0;
        while (int_o !== 1'b1 && k < bound) begin
            @(posedge clk_i);
            k++;
        end
        if (int_o !== 1'b1) begin
            num_errors++;
            $display("MISMATCH pulse_int_o expected 1 seen %b", int_o);
            report_and_stop();
        end
    endtask

    // ********************
    // Sequence
    // ********************
    initial begin
        idle(12);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            host.read_reg(row_a[i], rd_v);
            check("reset value", 8'h00, rd_v);
        end
        for (int i = 0; i < 8; i++) begin
            host.write_reg(row_a[i], row_d[i]);
            host.read_reg(row_a[i], rd_v);
            check("readback", row_e[i], rd_v);
        end
        host.rmw(ADDR_CTRL_TWO, 8'hfd, 8'h00);
        host.read_reg(ADDR_CTRL_TWO, rd_v);
        check("polarity cleared", 8'h05, rd_v);
        host.rmw(ADDR_CTRL_ONE, 8'h87, 8'h00);
        host.write_reg(ADDR_WIDTH, 8'h10);
        host.write_reg(ADDR_WINDOW, 8'h00);
        pulse(1, 8'h50);
        wait_int(40);
        check("y pulse", 8'h02, {5'h00, src});
        check("single kind", 8'h00, {7'h00, dbl});
        clear_flags();
        pulse(0, 8'hc0);
        wait_int(40);
        check("x at threshold", 8'h01, {5'h00, src});
        clear_flags();
        pulse(2, 8'h3f);
        host.rmw(ADDR_CTRL_ONE, 8'hff, 8'h10);
        pulse(1, 8'h50);
        host.write_reg(ADDR_WIDTH, 8'h02);
        hit(0, 8'h50);
        idle(30);
        hit(0, 8'h00);
        idle(20);
        check("no pulse", 8'h00, {5'h00, src});
        host.rmw(ADDR_CTRL_ONE, 8'h98, 8'h18);
        host.write_reg(ADDR_WIDTH, 8'h3c);
        host.write_reg(ADDR_WINDOW, 8'h82);
        pulse(2, 8'h50);
        pulse(0, 8'h50);
        idle(100);
        pulse(2, 8'h50);
        idle(700);
        check("first silent", 8'h00, {5'h00, src});
        pulse(2, 8'h50);
        wait_int(40);
        check("double src", 8'h04, {5'h00, src});
        check("double kind", 8'h01, {7'h00, dbl});
        clear_flags();
        pulse(2, 8'h50);
        idle(1900);
        pulse(2, 8'h50);
        idle(20);
        check("window over", 8'h00, {5'h00, src});
        check("int idle", 8'h00, {7'h00, int_o});
        check("double cleared", 8'h00, {7'h00, dbl});
        acc[2] <= 8'h50;
        host.write_reg(ADDR_WINDOW, 8'h00);
        host.write_reg(ADDR_LATENCY, 8'h02);
        host.rmw(ADDR_CTRL_TWO, 8'hff, 8'h02);
        idle(30);
        check("held above", 8'h00, {5'h00, src});
        acc[2] <= 8'h00;
        idle(10);
        check("before latency", 8'h00, {5'h00, src});
        wait_int(40);
        check("freefall", 8'h04, {5'h00, src});
        ce_i <= 1'b0;
        clr <= 1'b1;
        idle(5);
        check("frozen", 8'h04, {5'h00, src});
        ce_i <= 1'b1;
        clr <= 1'b0;
        rst_n_i <= 1'b0;
        idle(2);
        rst_n_i <= 1'b1;
        idle(1);
        check("reset flags", 8'h00, {5'h00, src});
        host.read_reg(ADDR_CTRL_TWO, rd_v);
        check("reset polarity", 8'h00, rd_v);
        report_and_stop();
    end
endmodule

`default_nettype wire
